//--- hdl/etp_pkg.sv
// Constants for the 8-bit timer channel pair: register map, field layout, codes, reset values
package etp_pkg;

    // Register bus geometry; each index holds one byte per channel, even channel in the upper byte
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CH_EVEN = 0;
    localparam int CH_ODD = 1;

    // Register indices
    localparam logic [2:0] REG_TIMER_CONTROL = 3'h0;
    localparam logic [2:0] REG_TIMER_FLAGS_CONTROL = 3'h1;
    localparam logic [2:0] REG_MATCH_VALUE_A = 3'h2;
    localparam logic [2:0] REG_MATCH_VALUE_B = 3'h3;
    localparam logic [2:0] REG_TICK_COUNTER = 3'h4;

    // timer_control fields
    localparam int CTL_MATCH_B_IRQ_ENABLE = 7;
    localparam int CTL_MATCH_A_IRQ_ENABLE = 6;
    localparam int CTL_WRAP_IRQ_ENABLE = 5;
    localparam int CTL_CLEAR_SELECT_LO = 3;
    localparam int CTL_CLOCK_SELECT_LO = 0;

    // timer_flags_control fields
    localparam int FLG_MATCH_B = 7;
    localparam int FLG_MATCH_A = 6;
    localparam int FLG_WRAP = 5;
    localparam int FLG_CAPTURE_ENABLE_B = 4;
    localparam int FLG_OUTPUT_B_LO = 2;
    localparam int FLG_OUTPUT_A_LO = 0;
    localparam logic [7:0] FLG_RW_MASK = 8'h1F;

    // Reset values
    localparam logic [7:0] TICK_COUNTER_RESET = 8'h00;
    localparam logic [7:0] MATCH_VALUE_RESET = 8'hFF;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIMER_FLAGS_RESET = 8'h00;
    localparam logic [7:0] COUNTER_MAX = 8'hFF;

    // Clock select codes
    localparam logic [2:0] CKS_STOP = 3'h0;
    localparam logic [2:0] CKS_DIV8 = 3'h1;
    localparam logic [2:0] CKS_DIV64 = 3'h2;
    localparam logic [2:0] CKS_DIV8192 = 3'h3;
    localparam logic [2:0] CKS_CASCADE = 3'h4;
    localparam logic [2:0] CKS_EXT_FALL = 3'h5;
    localparam logic [2:0] CKS_EXT_RISE = 3'h6;
    localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

    // Prescaler widths giving divide by 8, 64 and 8192
    localparam int PRESCALE_W = 13;
    localparam int DIV8_BITS = 3;
    localparam int DIV64_BITS = 6;
    localparam int DIV8192_BITS = 13;

    // Clear select codes
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_MATCH_A = 2'h1;
    localparam logic [1:0] CLR_MATCH_B = 2'h2;
    localparam logic [1:0] CLR_CAPTURE_B = 2'h3;

    // Output select codes (compare mode) and capture edge codes (capture mode)
    localparam logic [1:0] OUT_KEEP = 2'h0;
    localparam logic [1:0] OUT_LOW = 2'h1;
    localparam logic [1:0] OUT_HIGH = 2'h2;
    localparam logic [1:0] OUT_TOGGLE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;

endpackage

//--- hdl/etp_timer_pair.sv
// Pair of 8-bit timer channels with compare, odd-channel capture, cascade and register port
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module etp_timer_pair #(
    parameter logic EVEN_BIT4_RESET = 1'b0 // Reset value of the even channel's spare flags bit 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    input wire logic [etp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [1:0] reg_be,
    input wire logic [etp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [etp_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [1:0] ext_clk,
    input wire logic capture_in,
    output logic [1:0] timer_out,
    output logic timer_out_odd_oe,
    output logic [1:0] match_a_irq,
    output logic [1:0] match_b_irq,
    output logic [1:0] wrap_irq
);
    import etp_pkg::*;

    // Writes land at the strobe edge.
    // Read data stand one cycle, else zero,
    // so slaves can be ORed onto one bus.
    // Reads return both lanes; lane enables
    // steer writes and pick which flags arm.
    // Unmapped indices read zero.

    // Whole state of the pair; index 0 is the even channel, index 1 the odd one
    typedef struct packed {
        logic [1:0][7:0] tick_counter;
        logic [1:0][7:0] match_value_a;
        logic [1:0][7:0] match_value_b;
        logic [1:0][7:0] timer_control;
        logic [1:0][7:0] timer_flags_control;
        logic [1:0] armed_match_b;
        logic [1:0] armed_match_a;
        logic [1:0] armed_wrap;
        logic [1:0] eq_a_prev;
        logic [1:0] eq_b_prev;
        logic [1:0] tmo;
        logic tmo_odd_oe;
        logic [1:0] irq_a;
        logic [1:0] irq_b;
        logic [1:0] irq_wrap;
        logic [1:0] ext_s1;
        logic [1:0] ext_s2;
        logic [1:0] ext_s3;
        logic cap_s1;
        logic cap_s2;
        logic cap_s3;
        logic [PRESCALE_W-1:0] prescale;
        logic [DATA_W-1:0] rdata;
    } etp_state_t;

    // Reset image, also loaded while standby is held
    function automatic etp_state_t reset_state();
        etp_state_t r;
        r = '0;
        for (int c = 0; c < 2; c++) begin
            r.tick_counter[c] = TICK_COUNTER_RESET;
            r.match_value_a[c] = MATCH_VALUE_RESET;
            r.match_value_b[c] = MATCH_VALUE_RESET;
            r.timer_control[c] = TIMER_CONTROL_RESET;
            r.timer_flags_control[c] = TIMER_FLAGS_RESET;
        end
        // Only the even spare bit differs by parameter
        r.timer_flags_control[CH_EVEN][FLG_CAPTURE_ENABLE_B] = EVEN_BIT4_RESET;
        r.tmo_odd_oe = 1'b1;
        return r;
    endfunction

    // Same image serves reset and standby
    localparam etp_state_t STATE_RESET = reset_state();

    // Prescaler tap: one pulse each time the low bits all read one
    function automatic logic div_tick(input logic [PRESCALE_W-1:0] pre, input int bits);
        logic [PRESCALE_W-1:0] mask;
        // Taps are one clock wide, shared in phase
        mask = PRESCALE_W'((1 << bits) - 1);
        return (pre & mask) == mask;
    endfunction

    // Byte lane of a channel: even channel upper byte, odd lower byte
    function automatic logic [7:0] lane_of(input logic [DATA_W-1:0] word, input int ch);
        // Channel is an int so callers can loop
        return (ch == CH_EVEN) ? word[15:8] : word[7:0];
    endfunction

    // New level of the timer output for a two-bit output select code
    function automatic logic out_level(input logic cur, input logic [1:0] sel);
        case (sel)
            OUT_LOW: return 1'b0;
            OUT_HIGH: return 1'b1;
            OUT_TOGGLE: return ~cur;
            // Keep also covers unknown codes
            default: return cur;
        endcase
    endfunction

    // Present and next state
    etp_state_t s_reg;
    etp_state_t s_next;

    // Per-channel combinational terms
    // Comparisons use registered values only
    logic [1:0] cap_mode;
    logic [1:0] eq_a;
    logic [1:0] eq_b;
    logic [1:0] evt_a;
    logic [1:0] evt_b;
    logic [1:0] cap_evt;
    logic [1:0] pulse;
    logic [1:0] wrap_evt;
    logic [1:0] clr_on_pulse;
    logic [1:0] ext_rise;
    logic [1:0] ext_fall;
    // Edge strobes, one cycle wide
    logic cap_rise;
    logic cap_fall;

    // Next-state logic for the whole pair
    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;
        cap_mode = '0;
        eq_a = '0;
        eq_b = '0;
        evt_a = '0;
        evt_b = '0;
        cap_evt = '0;
        pulse = '0;
        wrap_evt = '0;
        clr_on_pulse = '0;

        // Stage one may be metastable; only stage two reads it
        // Input synchronisers; only stage two and three feed edge detection
        s_next.ext_s1 = ext_clk;
        s_next.ext_s2 = s_reg.ext_s1;
        s_next.ext_s3 = s_reg.ext_s2;
        s_next.cap_s1 = capture_in;
        s_next.cap_s2 = s_reg.cap_s1;
        s_next.cap_s3 = s_reg.cap_s2;
        ext_rise = s_reg.ext_s2 & ~s_reg.ext_s3;
        ext_fall = ~s_reg.ext_s2 & s_reg.ext_s3;
        cap_rise = s_reg.cap_s2 & ~s_reg.cap_s3;
        cap_fall = ~s_reg.cap_s2 & s_reg.cap_s3;

        // Free-running prescaler shared by both channels
        s_next.prescale = s_reg.prescale + PRESCALE_W'(1);
        // Wraps at the slowest tap, so no tap is skipped

        // Flags follow equality while it lasts; the pin
        // reacts to its rising only, else a parked
        // counter would toggle the output every cycle.

        // Compare and capture detection from registered values
        for (int c = 0; c < 2; c++) begin
            cap_mode[c] = (c == CH_ODD) && s_reg.timer_flags_control[c][FLG_CAPTURE_ENABLE_B];
            eq_a[c] = s_reg.tick_counter[c] == s_reg.match_value_a[c];
            eq_b[c] = !cap_mode[c] && (s_reg.tick_counter[c] == s_reg.match_value_b[c]);
            evt_a[c] = eq_a[c] && !s_reg.eq_a_prev[c];
            evt_b[c] = eq_b[c] && !s_reg.eq_b_prev[c];
            if (cap_mode[c]) begin
                case (s_reg.timer_flags_control[c][FLG_OUTPUT_B_LO +: 2])
                    CAP_RISE: cap_evt[c] = cap_rise;
                    CAP_FALL: cap_evt[c] = cap_fall;
                    CAP_BOTH: cap_evt[c] = cap_rise | cap_fall;
                    default: cap_evt[c] = 1'b0;
                endcase
            end
            s_next.eq_a_prev[c] = eq_a[c];
            s_next.eq_b_prev[c] = eq_b[c];
        end

        // External edges act three edges after the pin.
        // Pulses under one clock wide may be missed.

        // Count pulses; odd first since the even cascade input is the odd wrap
        for (int c = 1; c >= 0; c--) begin
            case (s_reg.timer_control[c][CTL_CLOCK_SELECT_LO +: 3])
                CKS_STOP: pulse[c] = 1'b0;
                CKS_DIV8: pulse[c] = div_tick(s_reg.prescale, DIV8_BITS);
                CKS_DIV64: pulse[c] = div_tick(s_reg.prescale, DIV64_BITS);
                CKS_DIV8192: pulse[c] = div_tick(s_reg.prescale, DIV8192_BITS);
                // Mutual cascade is not blocked: odd counts even match A events, even counts odd wraps; the software must avoid it
                CKS_CASCADE: pulse[c] = (c == CH_EVEN) ? wrap_evt[CH_ODD] : evt_a[CH_EVEN];
                CKS_EXT_FALL: pulse[c] = ext_fall[c];
                CKS_EXT_RISE: pulse[c] = ext_rise[c];
                CKS_EXT_BOTH: pulse[c] = ext_rise[c] | ext_fall[c];
                default: pulse[c] = 1'b0;
            endcase
            // Clear waits for the next pulse while equal
            case (s_reg.timer_control[c][CTL_CLEAR_SELECT_LO +: 2])
                CLR_MATCH_A: clr_on_pulse[c] = eq_a[c];
                CLR_MATCH_B: clr_on_pulse[c] = eq_b[c];
                default: clr_on_pulse[c] = 1'b0;
            endcase
            wrap_evt[c] = pulse[c] && !clr_on_pulse[c] && (s_reg.tick_counter[c] == COUNTER_MAX);
        end

        // Counter, capture and timer output per channel
        for (int c = 0; c < 2; c++) begin
            if (pulse[c]) begin
                if (clr_on_pulse[c]) begin
                    s_next.tick_counter[c] = TICK_COUNTER_RESET;
                end else begin
                    s_next.tick_counter[c] = s_reg.tick_counter[c] + 8'h01;
                end
            end
            if (cap_evt[c]) begin
                s_next.match_value_b[c] = s_reg.tick_counter[c];
                // Capture clear is immediate, so the captured value is the full period
                if (s_reg.timer_control[c][CTL_CLEAR_SELECT_LO +: 2] == CLR_MATCH_B ||
                    s_reg.timer_control[c][CTL_CLEAR_SELECT_LO +: 2] == CLR_CAPTURE_B) begin
                    s_next.tick_counter[c] = TICK_COUNTER_RESET;
                end
            end
            // Match B acts after match A, so B wins when both strike together
            if (evt_a[c]) begin
                s_next.tmo[c] = out_level(s_next.tmo[c], s_reg.timer_flags_control[c][FLG_OUTPUT_A_LO +: 2]);
            end
            if (evt_b[c]) begin
                s_next.tmo[c] = out_level(s_next.tmo[c], s_reg.timer_flags_control[c][FLG_OUTPUT_B_LO +: 2]);
            end
        end
        // Odd level still follows match A while the pin listens
        // The odd pin turns into the capture input while capture is enabled
        s_next.tmo_odd_oe = !cap_mode[CH_ODD];

        // Flags take no written ones; a zero clears
        // only after a read of that lane saw it set.
        // Arming is per lane, so reading the other
        // channel cannot open a clear of this one.

        // Register writes; a counter write overrides counting in the same cycle
        if (reg_wr) begin
            for (int c = 0; c < 2; c++) begin
                if (reg_be[1 - c]) begin
                    case (reg_addr)
                        REG_TIMER_CONTROL: s_next.timer_control[c] = lane_of(reg_wdata, c);
                        REG_TIMER_FLAGS_CONTROL: begin
                            s_next.timer_flags_control[c] = (s_reg.timer_flags_control[c] & ~FLG_RW_MASK) |
                                (lane_of(reg_wdata, c) & FLG_RW_MASK);
                            // Writing one leaves a flag alone; zero clears only after a read of one
                            if (!reg_wdata[8 * (1 - c) + FLG_MATCH_B] && s_reg.armed_match_b[c]) begin
                                s_next.timer_flags_control[c][FLG_MATCH_B] = 1'b0;
                            end
                            if (!reg_wdata[8 * (1 - c) + FLG_MATCH_A] && s_reg.armed_match_a[c]) begin
                                s_next.timer_flags_control[c][FLG_MATCH_A] = 1'b0;
                            end
                            if (!reg_wdata[8 * (1 - c) + FLG_WRAP] && s_reg.armed_wrap[c]) begin
                                s_next.timer_flags_control[c][FLG_WRAP] = 1'b0;
                            end
                            s_next.armed_match_b[c] = 1'b0;
                            s_next.armed_match_a[c] = 1'b0;
                            s_next.armed_wrap[c] = 1'b0;
                        end
                        // A match B write beats a capture
                        REG_MATCH_VALUE_A: s_next.match_value_a[c] = lane_of(reg_wdata, c);
                        REG_MATCH_VALUE_B: s_next.match_value_b[c] = lane_of(reg_wdata, c);
                        REG_TICK_COUNTER: s_next.tick_counter[c] = lane_of(reg_wdata, c);
                        default: ;
                    endcase
                end
            end
        end

        // A count in the read cycle shows next time
        // Register reads: data in the next cycle; reading the flags arms their clear
        if (reg_rd) begin
            for (int c = 0; c < 2; c++) begin
                case (reg_addr)
                    // Both lanes, whatever the enables
                    REG_TIMER_CONTROL: s_next.rdata[8 * (1 - c) +: 8] = s_reg.timer_control[c];
                    REG_TIMER_FLAGS_CONTROL: begin
                        s_next.rdata[8 * (1 - c) +: 8] = s_reg.timer_flags_control[c];
                        if (reg_be[1 - c]) begin
                            s_next.armed_match_b[c] = s_reg.timer_flags_control[c][FLG_MATCH_B];
                            s_next.armed_match_a[c] = s_reg.timer_flags_control[c][FLG_MATCH_A];
                            s_next.armed_wrap[c] = s_reg.timer_flags_control[c][FLG_WRAP];
                        end
                    end
                    REG_MATCH_VALUE_A: s_next.rdata[8 * (1 - c) +: 8] = s_reg.match_value_a[c];
                    REG_MATCH_VALUE_B: s_next.rdata[8 * (1 - c) +: 8] = s_reg.match_value_b[c];
                    REG_TICK_COUNTER: s_next.rdata[8 * (1 - c) +: 8] = s_reg.tick_counter[c];
                    default: s_next.rdata[8 * (1 - c) +: 8] = 8'h00;
                endcase
            end
        end

        // Hardware flag sets come last so a set beats a same-cycle clear
        for (int c = 0; c < 2; c++) begin
            if (eq_a[c]) begin
                s_next.timer_flags_control[c][FLG_MATCH_A] = 1'b1;
            end
            if (eq_b[c] || cap_evt[c]) begin
                s_next.timer_flags_control[c][FLG_MATCH_B] = 1'b1;
            end
            if (wrap_evt[c]) begin
                s_next.timer_flags_control[c][FLG_WRAP] = 1'b1;
            end
            // Requests rise with their flag
            s_next.irq_b[c] = s_next.timer_flags_control[c][FLG_MATCH_B] &
                s_next.timer_control[c][CTL_MATCH_B_IRQ_ENABLE];
            s_next.irq_a[c] = s_next.timer_flags_control[c][FLG_MATCH_A] &
                s_next.timer_control[c][CTL_MATCH_A_IRQ_ENABLE];
            s_next.irq_wrap[c] = s_next.timer_flags_control[c][FLG_WRAP] &
                s_next.timer_control[c][CTL_WRAP_IRQ_ENABLE];
        end

        // Standby reinitialises everything, as reset does
        // Synchronous: standby needs a running clock
        if (standby) begin
            s_next = STATE_RESET;
        end
    end

    // State register
    // Async reset loads constants only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    // Nothing combinational reaches a pin
    assign reg_rdata = s_reg.rdata;
    assign timer_out = s_reg.tmo;
    assign timer_out_odd_oe = s_reg.tmo_odd_oe;
    assign match_a_irq = s_reg.irq_a;
    assign match_b_irq = s_reg.irq_b;
    assign wrap_irq = s_reg.irq_wrap;

endmodule // etp_timer_pair

`default_nettype wire

//--- testbench/etp_timer_pair_props.sv
// Concurrent checks on the timer pair's register port and outputs
`timescale 1ns/1ps
`default_nettype none
module etp_timer_pair_props
    import etp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    input wire logic [2:0] reg_addr,
    input wire logic [1:0] reg_be,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0] ext_clk,
    input wire logic capture_in,
    input wire logic [1:0] timer_out,
    input wire logic timer_out_odd_oe,
    input wire logic [1:0] match_a_irq,
    input wire logic [1:0] match_b_irq,
    input wire logic [1:0] wrap_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Word written then read at once must come back whole, even byte on top
    property word_back(logic [2:0] idx);
        $past(reg_wr, 2) && $past(reg_addr, 2) == idx && $past(reg_be, 2) == 2'h3 && $past(reg_rd)
            && $past(reg_addr) == idx && !$past(standby) && !$past(standby, 2) |-> reg_rdata == $past(reg_wdata, 2);
    endproperty
    // Read data stand only in the slot after a strobe, so stale data cannot leak
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the read slot");
    unmapped_read_a: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 16'h0000)
        else $error("unmapped index returned data");
    match_a_back_a: assert property (word_back(REG_MATCH_VALUE_A))
        else $error("match A word read back wrong");
    control_back_a: assert property (word_back(REG_TIMER_CONTROL))
        else $error("control word read back wrong");
    standby_clear_a: assert property (standby |=> timer_out == 2'h0 && timer_out_odd_oe && match_a_irq == 2'h0
        && match_b_irq == 2'h0 && wrap_irq == 2'h0)
        else $error("outputs not at reset level in standby");
    irq_a_mask_a: assert property (reg_wr && reg_addr == REG_TIMER_CONTROL && reg_be[1] && !reg_wdata[14]
        |-> ##[1:2] !match_a_irq[0])
        else $error("match A request not suppressed");
    irq_b_mask_a: assert property (reg_wr && reg_addr == REG_TIMER_CONTROL && reg_be[0] && !reg_wdata[7]
        |-> ##[1:2] !match_b_irq[1])
        else $error("match B request not suppressed");
    wrap_mask_a: assert property (reg_wr && reg_addr == REG_TIMER_CONTROL && reg_be[0] && !reg_wdata[5]
        |-> ##[1:2] !wrap_irq[1])
        else $error("wrap request not suppressed");
    capture_oe_a: assert property (reg_wr && reg_addr == REG_TIMER_FLAGS_CONTROL && reg_be[0] && reg_wdata[4]
        |-> ##[1:2] !timer_out_odd_oe)
        else $error("odd pin still driven in capture mode");
    cover property ($rose(wrap_irq[1]));
    cover property ($fell(timer_out_odd_oe));
    cover property ($rose(timer_out[1]));
endmodule // etp_timer_pair_props
bind etp_timer_pair etp_timer_pair_props i_etp_timer_pair_props (.clock(clock), .rst(rst), .standby(standby),
    .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_clk(ext_clk), .capture_in(capture_in), .timer_out(timer_out),
    .timer_out_odd_oe(timer_out_odd_oe), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .wrap_irq(wrap_irq));
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the timer channel pair
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import etp_pkg::*;
    typedef struct packed {logic [15:0] lo; logic [15:0] hi;} etp_exp_t;
    logic clock, rst, standby, reg_wr, reg_rd, capture_in, timer_out_odd_oe, rd_seen;
    logic [2:0] reg_addr;
    logic [1:0] reg_be, ext_clk, timer_out, match_a_irq, match_b_irq, wrap_irq;
    logic [15:0] reg_wdata, reg_rdata, rv;
    etp_exp_t exp_q[$];
    int err_total = 0;
    int n_checks = 0;
    etp_timer_pair i_etp_timer_pair (.clock(clock), .rst(rst), .standby(standby), .reg_addr(reg_addr),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_clk(ext_clk), .capture_in(capture_in), .timer_out(timer_out), .timer_out_odd_oe(timer_out_odd_oe),
        .match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .wrap_irq(wrap_irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        n_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wrap_up();
        if (exp_q.size() != 0) err_total++;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Strobes stay up between back-to-back calls; gap drops them
    task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
        reg_wr <= 1'b1; reg_rd <= 1'b0; reg_addr <= a; reg_be <= be; reg_wdata <= d;
        @(posedge clock);
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] lo, input logic [15:0] hi);
        exp_q.push_back('{lo, hi});
        reg_wr <= 1'b0; reg_rd <= 1'b1; reg_addr <= a; reg_be <= 2'h3;
        @(posedge clock);
    endtask
    task automatic rde(input logic [2:0] a, input logic [15:0] v);
        rd(a, v, v);
    endtask
    task automatic gap(input int n);
        reg_wr <= 1'b0; reg_rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    // Each toggle waits out the three-flop input path before the next
    task automatic pulse_ext(input int n);
        repeat (n) begin
            ext_clk <= ~ext_clk; // Both pins; channels not on ext clock ignore it
            repeat (4) @(posedge clock);
        end
    endtask
    task automatic reset_values();
        logic [15:0] tbl [6];
        tbl = '{16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
        for (int i = 0; i < 6; i++) rde(3'(i), tbl[i]);
        gap(1);
    endtask
    task automatic done(input string s);
        $display("test %0s done at %0t", s, $time);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Read results are judged half a cycle after they land
    always @(posedge clock or posedge rst) if (rst) rd_seen <= 1'b0; else rd_seen <= reg_rd;
    always @(negedge clock) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) chk(reg_rdata, 16'h0001, 16'h0000);
            else chk(reg_rdata, exp_q[0].lo, exp_q[0].hi);
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        wrap_up();
    end
    initial begin
        logic [15:0] lo_t [4];
        logic [15:0] hi_t [4];
        int waits [4];
        lo_t = '{16'h0000, 16'd99, 16'd99, 16'd1};
        hi_t = '{16'h0000, 16'd101, 16'd101, 16'd3};
        waits = '{100, 800, 6400, 16384};
        rst = 1'b1; standby = 1'b0; reg_addr = 3'h0; reg_be = 2'h0; reg_wdata = 16'h0000;
        reg_wr = 1'b0; reg_rd = 1'b0; ext_clk = 2'h0; capture_in = 1'b0;
        void'($urandom(32'hced7));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        reset_values();
        done("reset");
        rv = 16'($urandom());
        wr(REG_MATCH_VALUE_A, 2'h3, rv);
        rde(REG_MATCH_VALUE_A, rv);
        wr(REG_MATCH_VALUE_A, 2'h2, ~rv);
        rde(REG_MATCH_VALUE_A, {~rv[15:8], rv[7:0]});
        wr(REG_TIMER_CONTROL, 2'h3, 16'h0800);
        rde(REG_TIMER_CONTROL, 16'h0800);
        wr(REG_MATCH_VALUE_A, 2'h3, 16'hFFFF);
        wr(REG_TICK_COUNTER, 2'h3, rv & 16'hFEFE);
        rde(REG_TICK_COUNTER, rv & 16'hFEFE);
        gap(1);
        done("word access");
        // Prescaler phase is free running, so allow one count either way
        for (int c = 0; c < 4; c++) begin
            wr(REG_TIMER_CONTROL, 2'h3, 16'h0000);
            wr(REG_TICK_COUNTER, 2'h3, 16'h0000);
            wr(REG_TIMER_CONTROL, 2'h1, {13'h0000, 3'(c)});
            gap(waits[c]);
            rd(REG_TICK_COUNTER, lo_t[c], hi_t[c]);
            gap(1);
        end
        done("prescaler");
        for (int c = 5; c < 8; c++) begin
            wr(REG_TIMER_CONTROL, 2'h3, 16'h0000);
            wr(REG_TICK_COUNTER, 2'h3, 16'h0000);
            wr(REG_TIMER_CONTROL, 2'h1, {13'h0000, 3'(c)});
            gap(2);
            pulse_ext(10);
            rde(REG_TICK_COUNTER, (c == 7) ? 16'h000A : 16'h0005);
            gap(1);
        end
        done("external clock");
        wr(REG_TIMER_CONTROL, 2'h3, 16'h0000);
        wr(REG_TICK_COUNTER, 2'h3, 16'h00FE);
        rd(REG_TIMER_FLAGS_CONTROL, 16'h0000, 16'hFFFF);
        wr(REG_TIMER_FLAGS_CONTROL, 2'h3, 16'h0000);
        wr(REG_TIMER_CONTROL, 2'h3, 16'h0426);
        gap(2);
        pulse_ext(4);
        rde(REG_TICK_COUNTER, 16'h0100);
        rde(REG_TIMER_FLAGS_CONTROL, 16'h00E0);
        gap(1);
        chk({14'h0000, wrap_irq}, 16'h0002, 16'h0002);
        chk({14'h0000, match_a_irq}, 16'h0000, 16'h0000);
        wr(REG_TIMER_FLAGS_CONTROL, 2'h1, 16'h00E0);
        rde(REG_TIMER_FLAGS_CONTROL, 16'h00E0);
        wr(REG_TIMER_FLAGS_CONTROL, 2'h1, 16'h0000);
        rde(REG_TIMER_FLAGS_CONTROL, 16'h0000);
        gap(2);
        chk({14'h0000, wrap_irq}, 16'h0000, 16'h0000);
        done("cascade and flags");
        wr(REG_TIMER_CONTROL, 2'h3, 16'h0000);
        wr(REG_TICK_COUNTER, 2'h3, 16'h0100);
        wr(REG_MATCH_VALUE_A, 2'h3, 16'hFF03);
        wr(REG_TIMER_FLAGS_CONTROL, 2'h1, 16'h0003);
        wr(REG_TIMER_CONTROL, 2'h1, 16'h004E);
        gap(2);
        pulse_ext(12);
        rde(REG_TICK_COUNTER, 16'h0102);
        gap(2);
        chk({14'h0000, timer_out}, 16'h0002, 16'h0002);
        chk({14'h0000, match_a_irq}, 16'h0002, 16'h0002);
        done("clear on match");
        wr(REG_TIMER_CONTROL, 2'h3, 16'h0000);
        wr(REG_TIMER_FLAGS_CONTROL, 2'h1, 16'h0010);
        gap(2);
        capture_in <= 1'b1;
        gap(6);
        rde(REG_MATCH_VALUE_B, 16'hFF02);
        rde(REG_TIMER_FLAGS_CONTROL, 16'h00D0);
        gap(1);
        done("capture");
        wr(REG_TIMER_FLAGS_CONTROL, 2'h2, 16'h0C00);
        wr(REG_MATCH_VALUE_B, 2'h2, 16'h0200);
        wr(REG_TICK_COUNTER, 2'h2, 16'h0000);
        wr(REG_TIMER_CONTROL, 2'h2, 16'h8600);
        gap(2);
        pulse_ext(4);
        rde(REG_TICK_COUNTER, 16'h0202);
        gap(1);
        chk({14'h0000, timer_out}, 16'h0003, 16'h0003);
        chk({14'h0000, match_b_irq}, 16'h0001, 16'h0001);
        done("match B");
        standby <= 1'b1;
        gap(2);
        standby <= 1'b0;
        gap(1);
        reset_values();
        done("standby");
        gap(3);
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
